// [inc/fpu_csr_pkg.sv]
// fpu_csr_pkg: layouts, classes and carriers of the fpu csr block
// assumes every user imports the whole package; one clock domain
package fpu_csr_pkg;

    // ********************************************
    // widths and reset values
    // ********************************************
    localparam int DATA_W = 32;
    localparam int CTRL_STORE_W = 16;
    localparam int CTRL_RSVD_W = DATA_W - CTRL_STORE_W;
    localparam logic [CTRL_RSVD_W-1:0] CTRL_RSVD_READ = 16'h0000;
    localparam logic [DATA_W-1:0] ADDR_RESET = 32'h0000_0000;
    // all-zero mode byte means round to nearest, extended width
    localparam logic [1:0] ROUND_DEFAULT = 2'h0;
    localparam logic [1:0] WIDTH_DEFAULT = 2'h0;

    // ********************************************
    // field layouts, most significant field first
    // ********************************************
    typedef struct packed {
        logic branch_unordered_flag;
        logic signaling_nan_flag;
        logic operand_error_flag;
        logic overflow_flag;
        logic underflow_flag;
        logic divide_by_zero_flag;
        logic imprecise_operation_flag;
        logic imprecise_decimal_input_flag;
    } fault_status_t;

    typedef struct packed {
        logic invalid_op_sticky;
        logic overflow_flag;
        logic underflow_flag;
        logic divide_by_zero_flag;
        logic imprecise_result_flag;
    } sticky_fault_t;

    typedef struct packed {
        fault_status_t trap_enable;
        logic [1:0] mantissa_width_select;
        logic [1:0] round_direction_field;
        logic [1:0] mode_spare;
        // fills the stored half out to its full sixteen bits
        logic [1:0] mode_low_spare;
    } ctrl_store_t;

    typedef struct packed {
        logic [3:0] spare_hi;
        logic [3:0] fp_condition_bits;
        logic quot_sign;
        logic [6:0] quot_magnitude;
        fault_status_t fault_status_byte;
        sticky_fault_t sticky_fault_byte;
        logic [2:0] spare_lo;
    } status_word_t;

    localparam ctrl_store_t CTRL_RESET = '0;
    localparam status_word_t STATUS_RESET = '0;

    // ********************************************
    // instruction classes and carriers
    // ********************************************
    typedef enum logic [1:0] {SEL_CTRL, SEL_STATUS, SEL_ADDR, SEL_NONE}
        reg_sel_t;

    typedef enum logic [2:0] {OP_ARITH, OP_MOVE_IN, OP_MOVE_OUT,
        OP_MULTI_MOVE, OP_SYS_MOVE} op_class_t;

    typedef struct packed {
        logic valid;
        logic write;
        reg_sel_t sel;
        logic [DATA_W-1:0] wdata;
    } csr_req_t;

    typedef struct packed {
        logic valid;
        op_class_t cls;
        logic [DATA_W-1:0] addr;
    } issue_t;

    typedef struct packed {
        logic valid;
        op_class_t cls;
        logic [3:0] cond;
        logic quot_wr;
        logic quot_sign;
        logic [6:0] quot_magnitude;
        fault_status_t faults;
    } done_t;

    // ********************************************
    // class decoding
    // ********************************************
    function automatic logic can_fault(input op_class_t cls);
        return cls == OP_ARITH || cls == OP_MOVE_IN || cls == OP_MOVE_OUT;
    endfunction

    function automatic logic sets_cond(input op_class_t cls);
        return cls == OP_ARITH || cls == OP_MOVE_IN;
    endfunction

    function automatic logic accrues(input op_class_t cls);
        return cls == OP_ARITH;
    endfunction

endpackage

// [hw/sticky_fault_merge.sv]
// sticky_fault_merge: folds per-op fault flags into sticky form
// assumes a pure combinational use by the csr block
`timescale 1ns/1ps
module sticky_fault_merge
    import fpu_csr_pkg::*;
(
    // per-op flags in, sticky contribution out
    input fault_status_t faults,
    output sticky_fault_t merged
);

    always_comb
    begin
        merged.invalid_op_sticky = faults.signaling_nan_flag
            | faults.operand_error_flag; // RULE_15
        merged.overflow_flag = faults.overflow_flag; // RULE_15
        // underflow only counts when the result was also inexact
        merged.underflow_flag = faults.underflow_flag
            & faults.imprecise_operation_flag; // RULE_15
        merged.divide_by_zero_flag = faults.divide_by_zero_flag;
        merged.imprecise_result_flag = faults.imprecise_decimal_input_flag
            | faults.imprecise_operation_flag
            | faults.overflow_flag; // RULE_15
    end

endmodule // sticky_fault_merge

// [hw/fault_addr_latch.sv]
// fault_addr_latch: holds the address of the last fault-capable op
// assumes issue and write strobes come from the same clock domain
`timescale 1ns/1ps
module fault_addr_latch
    import fpu_csr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic null_restore,
    // issue and software write
    input issue_t issue,
    input wire logic wr_en,
    input wire logic [DATA_W-1:0] wdata,
    // held address
    output logic [DATA_W-1:0] fp_fault_instr_addr_q
);

    logic capture;

    // moves of control registers and multi moves never fault, so skip
    assign capture = issue.valid && can_fault(issue.cls); // RULE_19

    always_ff @(posedge clk)
    begin
        if (!rst_n || null_restore)
            fp_fault_instr_addr_q <= ADDR_RESET; // RULE_20
        else if (capture)
            fp_fault_instr_addr_q <= issue.addr; // RULE_18
        else if (wr_en)
            fp_fault_instr_addr_q <= wdata;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_addr_capture: assert property ( // RULE_18
        capture && !null_restore |=> fp_fault_instr_addr_q == $past(issue.addr)
    ) else $error("fault address not captured at issue");

    a_addr_hold: assert property ( // RULE_19
        !capture && !wr_en && !null_restore |=> $stable(fp_fault_instr_addr_q)
    ) else $error("fault address changed without cause");

    a_addr_clear: assert property ( // RULE_20
        null_restore |=> fp_fault_instr_addr_q == ADDR_RESET
    ) else $error("null restore left fault address");

endmodule // fault_addr_latch

// [hw/fpu_status_control_regs.sv]
// fpu_status_control_regs: control, status and fault address of the fpu
// assumes issue, done, register moves and null restore all arrive on clk
// from logic in the same domain; one register move per cycle at most
//
// What this block does
// RULE_01 - control upper half reads zero, ignores writes
// RULE_02 - reset or null restore clears control
// RULE_03 - zero mode byte gives default rounding
// RULE_04 - one trap enable per exception class
// RULE_05 - mode byte holds direction and width fields
// RULE_06 - reset or null restore clears status
// RULE_07 - status fully readable, writable, updated by ops
// RULE_08 - arithmetic completion updates four condition bits
// RULE_09 - moves out and control moves keep conditions
// RULE_10 - quotient: seven magnitude bits plus sign
// RULE_11 - quotient holds until software clears it
// RULE_12 - fault byte cleared when capable op starts; a capable completion in the same cycle wins instead
// RULE_13 - non-faulting ops leave fault byte alone
// RULE_14 - five sticky flags accrue except on moves
// RULE_15 - sticky flags follow the fixed merge equations
// RULE_16 - software sticky writes never cause traps
// RULE_17 - only software, reset, restore clear sticky
// RULE_18 - capture faulting instruction address at issue
// RULE_19 - control moves and multi moves keep address
// RULE_20 - reset or null restore clears address
// RULE_21 - issue and completion may overlap freely
// RULE_22 - enabled fault at completion requests a trap
`timescale 1ns/1ps
module fpu_status_control_regs
    import fpu_csr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic null_restore,
    // register moves from the integer unit
    input csr_req_t csr_req,
    output logic csr_rvalid_q,
    output logic [DATA_W-1:0] csr_rdata_q,
    // instruction issue and completion from the pipeline
    input issue_t issue,
    input done_t done,
    // state seen by the pipeline and exception logic
    output ctrl_store_t ctrl_q,
    output status_word_t status_q,
    output logic ieee_default_mode_q,
    output logic trap_req_q
);

    // ********************************************
    // decode
    // ********************************************
    logic wr_ctrl;
    logic wr_status;
    logic wr_addr;
    logic rd_req;
    logic done_fault;
    logic done_cond;
    logic done_accrue;
    logic start_fault;
    logic trap_hit;
    status_word_t wr_word;
    ctrl_store_t ctrl_word;
    sticky_fault_t merged;
    sticky_fault_t sticky_base;
    logic [DATA_W-1:0] addr_q;

    assign wr_ctrl = csr_req.valid && csr_req.write
        && csr_req.sel == SEL_CTRL;
    assign wr_status = csr_req.valid && csr_req.write
        && csr_req.sel == SEL_STATUS;
    assign wr_addr = csr_req.valid && csr_req.write
        && csr_req.sel == SEL_ADDR;
    assign rd_req = csr_req.valid && !csr_req.write;
    assign wr_word = status_word_t'(csr_req.wdata);
    assign ctrl_word = ctrl_store_t'(csr_req.wdata[CTRL_STORE_W-1:0]);

    // issue and done are decoded apart: two ops may be in flight
    assign start_fault = issue.valid && can_fault(issue.cls); // RULE_21
    assign done_fault = done.valid && can_fault(done.cls);
    assign done_cond = done.valid && sets_cond(done.cls); // RULE_09
    assign done_accrue = done.valid && accrues(done.cls); // RULE_14

    // only completion flags are looked at, never a software write
    assign trap_hit = done_fault
        && |(done.faults & ctrl_q.trap_enable); // RULE_16

    sticky_fault_merge u_merge
    (
        .faults(done.faults),
        .merged(merged)
    );

    fault_addr_latch u_addr
    (
        .clk(clk),
        .rst_n(rst_n),
        .null_restore(null_restore),
        .issue(issue),
        .wr_en(wr_addr),
        .wdata(csr_req.wdata),
        .fp_fault_instr_addr_q(addr_q)
    );

    // ********************************************
    // control register
    // ********************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n || null_restore)
            ctrl_q <= CTRL_RESET; // RULE_02
        else if (wr_ctrl)
            // upper half is dropped, each enable bit stored alone
            ctrl_q <= ctrl_word;
    end // RULE_01 RULE_04 RULE_05

    // datapath sees defaults whenever both mode fields are zero
    always_ff @(posedge clk)
    begin
        if (!rst_n || null_restore)
            ieee_default_mode_q <= 1'b1; // RULE_03
        else if (wr_ctrl)
        begin
            ieee_default_mode_q <= // RULE_03
                ctrl_word.mantissa_width_select == WIDTH_DEFAULT
                && ctrl_word.round_direction_field == ROUND_DEFAULT;
        end
    end

    // ********************************************
    // condition bits
    // ********************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n || null_restore)
            status_q.fp_condition_bits <= STATUS_RESET.fp_condition_bits;
        else if (done_cond)
            status_q.fp_condition_bits <= done.cond; // RULE_08
        else if (wr_status)
            status_q.fp_condition_bits <= wr_word.fp_condition_bits;
    end // RULE_06 RULE_07

    // ********************************************
    // quotient byte
    // ********************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n || null_restore)
        begin
            status_q.quot_sign <= STATUS_RESET.quot_sign;
            status_q.quot_magnitude <= STATUS_RESET.quot_magnitude;
        end
        else if (done.valid && done.quot_wr)
        begin
            status_q.quot_sign <= done.quot_sign; // RULE_10
            status_q.quot_magnitude <= done.quot_magnitude; // RULE_10
        end
        else if (wr_status)
        begin
            // otherwise held: only software, reset or null restore clears it
            status_q.quot_sign <= wr_word.quot_sign; // RULE_11
            status_q.quot_magnitude <= wr_word.quot_magnitude;
        end
    end

    // ********************************************
    // per-op fault byte
    // ********************************************
    // completion wins over a new start in the same cycle so that the
    // finishing op's flags are seen by a handler reading right after
    always_ff @(posedge clk)
    begin
        if (!rst_n || null_restore)
            status_q.fault_status_byte <= STATUS_RESET.fault_status_byte;
        else if (done_fault)
            status_q.fault_status_byte <= done.faults; // RULE_12
        else if (start_fault)
            status_q.fault_status_byte <= '0; // RULE_12
        else if (wr_status)
            status_q.fault_status_byte <= wr_word.fault_status_byte;
    end // RULE_13

    // ********************************************
    // sticky fault byte
    // ********************************************
    // a software write replaces the byte, and a completion in that
    // same cycle still ORs on top, so no event is lost
    assign sticky_base = wr_status ? wr_word.sticky_fault_byte
        : status_q.sticky_fault_byte; // RULE_17

    always_ff @(posedge clk)
    begin
        if (!rst_n || null_restore)
            status_q.sticky_fault_byte <= STATUS_RESET.sticky_fault_byte;
        else if (done_accrue)
            status_q.sticky_fault_byte <= sticky_base | merged; // RULE_14
        else
            status_q.sticky_fault_byte <= sticky_base;
    end

    // ********************************************
    // spare status bits
    // ********************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n || null_restore)
        begin
            status_q.spare_hi <= STATUS_RESET.spare_hi;
            status_q.spare_lo <= STATUS_RESET.spare_lo;
        end
        else if (wr_status)
        begin
            status_q.spare_hi <= wr_word.spare_hi; // RULE_07
            status_q.spare_lo <= wr_word.spare_lo;
        end
    end

    // ********************************************
    // register read port
    // ********************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            csr_rvalid_q <= 1'b0;
            csr_rdata_q <= ADDR_RESET;
        end
        else
        begin
            csr_rvalid_q <= rd_req;
            if (rd_req)
            begin
                case (csr_req.sel)
                    SEL_CTRL:
                        csr_rdata_q <= {CTRL_RSVD_READ, ctrl_q}; // RULE_01
                    SEL_STATUS:
                        csr_rdata_q <= status_q; // RULE_07
                    SEL_ADDR:
                        csr_rdata_q <= addr_q;
                    default:
                        csr_rdata_q <= ADDR_RESET;
                endcase
            end
        end
    end

    // ********************************************
    // trap request
    // ********************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n || null_restore)
            trap_req_q <= 1'b0;
        else
            trap_req_q <= trap_hit; // RULE_22
    end

    // ********************************************
    // checks
    // ********************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_quiet_status;
        !wr_status && !null_restore;
    endsequence

    sequence s_enabled_fault;
        done_fault && |(done.faults & ctrl_q.trap_enable) && !null_restore;
    endsequence

    a_ctrl_upper_zero: assert property ( // RULE_01
        rd_req && csr_req.sel == SEL_CTRL
            |=> csr_rdata_q[DATA_W-1:CTRL_STORE_W] == CTRL_RSVD_READ
    ) else $error("control upper half read nonzero");

    a_restore_clears: assert property ( // RULE_02
        null_restore |=> ctrl_q == CTRL_RESET && status_q == STATUS_RESET
            && ieee_default_mode_q
    ) else $error("null restore left state behind");

    a_cond_update: assert property ( // RULE_08
        done_cond && !null_restore
            |=> status_q.fp_condition_bits == $past(done.cond)
    ) else $error("condition bits not updated");

    a_cond_hold: assert property ( // RULE_09
        !done_cond ##0 s_quiet_status |=> $stable(status_q.fp_condition_bits)
    ) else $error("condition bits changed by a move");

    a_quot_hold: assert property ( // RULE_11
        !(done.valid && done.quot_wr) ##0 s_quiet_status
            |=> $stable({status_q.quot_sign, status_q.quot_magnitude})
    ) else $error("quotient changed without cause");

    a_fault_clear: assert property ( // RULE_12
        start_fault && !done_fault ##0 s_quiet_status
            |=> status_q.fault_status_byte == '0
    ) else $error("fault byte not cleared at start");

    a_fault_keep: assert property ( // RULE_13
        !start_fault && !done_fault ##0 s_quiet_status
            |=> $stable(status_q.fault_status_byte)
    ) else $error("fault byte touched by safe op");

    a_sticky_merge: assert property ( // RULE_15
        done_accrue ##0 s_quiet_status |=> status_q.sticky_fault_byte
            == ($past(status_q.sticky_fault_byte) | $past(merged))
    ) else $error("sticky merge wrong");

    a_sticky_keep: assert property ( // RULE_17
        s_quiet_status |=> (status_q.sticky_fault_byte
            & $past(status_q.sticky_fault_byte))
            == $past(status_q.sticky_fault_byte)
    ) else $error("sticky flag dropped by execution");

    a_trap_raise: assert property ( // RULE_22
        s_enabled_fault |=> trap_req_q
    ) else $error("enabled fault gave no trap");

    a_trap_only_enabled: assert property ( // RULE_22
        !(done_fault && |(done.faults & ctrl_q.trap_enable)) |=> !trap_req_q
    ) else $error("trap without an enabled fault");

    a_trap_no_sw: assert property ( // RULE_16
        wr_status && !done_fault |=> !trap_req_q
    ) else $error("software write raised a trap");

endmodule // fpu_status_control_regs

// [verification/fpu_pipe_model.sv]
// fpu_pipe_model: integer unit and fp pipeline driving the csr block
// assumes one clock; requests start 1 ns after a rising edge
`timescale 1ns/1ps
module fpu_pipe_model
    import fpu_csr_pkg::*;
(
    // clock
    input wire logic clk,
    // register moves
    output csr_req_t csr_req,
    input wire logic csr_rvalid_q,
    input wire logic [DATA_W-1:0] csr_rdata_q,
    // issue and completion
    output issue_t issue,
    output done_t done
);
    initial
    begin
        csr_req = '0;
        issue = '0;
        done = '0;
    end

    // one move; answer is sampled 1 ns after the taking edge
    task automatic mv(input logic wr, input reg_sel_t sel,
        input logic [DATA_W-1:0] wd, output logic rv,
        output logic [DATA_W-1:0] rd);
        @(posedge clk);
        #1;
        csr_req = '{1'b1, wr, sel, wd};
        @(posedge clk);
        #1;
        rv = csr_rvalid_q;
        rd = csr_rdata_q;
        // released data flips so a stale value can never match
        csr_req = '{1'b0, 1'b0, SEL_NONE, ~wd};
    endtask

    task automatic iss(input op_class_t cls, input logic [DATA_W-1:0] a);
        @(posedge clk);
        #1;
        issue = '{1'b1, cls, a};
        @(posedge clk);
        #1;
        issue = '{1'b0, cls, ~a};
    endtask

    task automatic fin(input op_class_t cls, input logic [3:0] c,
        input logic qw, input logic [7:0] q, input fault_status_t f);
        @(posedge clk);
        #1;
        done = '{1'b1, cls, c, qw, q[7], q[6:0], f};
        @(posedge clk);
        #1;
        done = '{1'b0, cls, ~c, 1'b0, ~q[7], ~q[6:0], ~f};
    endtask
endmodule // fpu_pipe_model

// [verification/fpu_status_control_regs_tb.sv]
// fpu_status_control_regs_tb: self-checking bench of the fpu csr block
// assumes the pipe model drives every request input
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module fpu_status_control_regs_tb
    import fpu_csr_pkg::*;
;
    logic clk;
    logic rst_n;
    logic null_restore;
    csr_req_t csr_req;
    logic csr_rvalid_q;
    logic [DATA_W-1:0] csr_rdata_q;
    issue_t issue;
    done_t done;
    ctrl_store_t ctrl_q;
    status_word_t status_q;
    logic ieee_default_mode_q;
    logic trap_req_q;
    int fails;
    int checks;
    logic rv;
    logic [DATA_W-1:0] rd;

    fpu_status_control_regs fpu_status_control_regs_i (.clk(clk),
        .rst_n(rst_n), .null_restore(null_restore), .csr_req(csr_req),
        .csr_rvalid_q(csr_rvalid_q), .csr_rdata_q(csr_rdata_q),
        .issue(issue), .done(done), .ctrl_q(ctrl_q), .status_q(status_q),
        .ieee_default_mode_q(ieee_default_mode_q), .trap_req_q(trap_req_q));
    fpu_pipe_model fpu_pipe_model_i (.clk(clk), .csr_req(csr_req),
        .csr_rvalid_q(csr_rvalid_q), .csr_rdata_q(csr_rdata_q),
        .issue(issue), .done(done));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic wr(input reg_sel_t s, input logic [DATA_W-1:0] d);
        fpu_pipe_model_i.mv(1'b1, s, d, rv, rd);
    endtask

    task automatic rd_chk(input reg_sel_t s, input logic [DATA_W-1:0] e);
        fpu_pipe_model_i.mv(1'b0, s, '0, rv, rd);
        `CHK("rvalid", 1'b1, rv)
        `CHK("rdata", e, rd)
    endtask

    task automatic finish_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic t_reset();
        rd_chk(SEL_CTRL, 32'h0000_0000);
        rd_chk(SEL_STATUS, 32'h0000_0000);
        rd_chk(SEL_ADDR, 32'h0000_0000);
        `CHK("ieee", 1'b1, ieee_default_mode_q)
        $display("test reset done");
    endtask

    task automatic t_ctrl();
        logic [DATA_W-1:0] m [3] = '{32'h10, 32'h40, 32'h0};
        wr(SEL_CTRL, 32'hFFFF_FFFF);
        rd_chk(SEL_CTRL, 32'h0000_FFFF);
        `CHK("trap_en", 8'hFF, ctrl_q.trap_enable)
        foreach (m[i])
        begin
            wr(SEL_CTRL, m[i]);
            @(posedge clk);
            #1;
            `CHK("ieee", m[i] == 0, ieee_default_mode_q)
        end
        wr(SEL_STATUS, 32'hFFFF_FFFF);
        rd_chk(SEL_STATUS, 32'hFFFF_FFFF);
        wr(SEL_ADDR, 32'h89AB_CDEF);
        rd_chk(SEL_ADDR, 32'h89AB_CDEF);
        rd_chk(SEL_NONE, 32'h0000_0000);
        $display("test ctrl done");
    endtask

    task automatic t_merge();
        // fault byte in, expected sticky out, overflow trap only enabled
        logic [7:0] f [8] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h0A, 8'h04,
            8'h01, 8'h80};
        logic [4:0] s [8] = '{5'h10, 5'h10, 5'h09, 5'h00, 5'h05, 5'h02,
            5'h01, 5'h00};
        wr(SEL_CTRL, 32'h0000_1000);
        foreach (f[i])
        begin
            wr(SEL_STATUS, 32'h0000_0000);
            fpu_pipe_model_i.fin(OP_ARITH, 4'hA, 1'b0, 8'h00, f[i]);
            `CHK("trap", f[i][4], trap_req_q)
            `CHK("sticky", s[i], status_q.sticky_fault_byte)
            `CHK("faults", f[i], status_q.fault_status_byte)
            `CHK("cond", 4'hA, status_q.fp_condition_bits)
            @(posedge clk);
            #1;
            `CHK("trap_end", 1'b0, trap_req_q)
        end
        $display("test merge done");
    endtask

    task automatic t_keep();
        op_class_t c [3] = '{OP_MOVE_OUT, OP_MULTI_MOVE, OP_SYS_MOVE};
        fpu_pipe_model_i.iss(OP_ARITH, 32'h0000_1234);
        rd_chk(SEL_ADDR, 32'h0000_1234);
        `CHK("fclr", 8'h00, status_q.fault_status_byte)
        fpu_pipe_model_i.fin(OP_ARITH, 4'h6, 1'b1, 8'hC5, 8'h10);
        `CHK("qsign", 1'b1, status_q.quot_sign)
        `CHK("qmag", 7'h45, status_q.quot_magnitude)
        fpu_pipe_model_i.fin(OP_ARITH, 4'h6, 1'b0, 8'h00, 8'h00);
        `CHK("qkeep", 7'h45, status_q.quot_magnitude)
        `CHK("skeep", 5'h09, status_q.sticky_fault_byte)
        fpu_pipe_model_i.iss(OP_MULTI_MOVE, 32'h0000_5555);
        fpu_pipe_model_i.iss(OP_SYS_MOVE, 32'h0000_6666);
        rd_chk(SEL_ADDR, 32'h0000_1234);
        wr(SEL_STATUS, 32'h0000_1000);
        foreach (c[i])
        begin
            fpu_pipe_model_i.fin(c[i], 4'h9, 1'b0, 8'h00, 8'h00);
            `CHK("ckeep", 4'h0, status_q.fp_condition_bits)
        end
        wr(SEL_STATUS, 32'h0000_1000);
        fpu_pipe_model_i.iss(OP_MULTI_MOVE, 32'h0000_5555);
        `CHK("fkeep", 8'h10, status_q.fault_status_byte)
        fpu_pipe_model_i.fin(OP_MOVE_OUT, 4'h0, 1'b0, 8'h00, 8'h04);
        `CHK("noacc", 5'h00, status_q.sticky_fault_byte)
        wr(SEL_CTRL, 32'h0000_FF00);
        // sampled in the cycle right after the write edge
        wr(SEL_STATUS, 32'h0000_FFF8);
        `CHK("swtrap", 1'b0, trap_req_q)
        $display("test keep done");
    endtask

    task automatic t_null();
        wr(SEL_CTRL, 32'h0000_F0F0);
        wr(SEL_ADDR, 32'h0000_0777);
        @(posedge clk);
        #1;
        null_restore = 1'b1;
        @(posedge clk);
        #1;
        null_restore = 1'b0;
        rd_chk(SEL_CTRL, 32'h0000_0000);
        rd_chk(SEL_STATUS, 32'h0000_0000);
        rd_chk(SEL_ADDR, 32'h0000_0000);
        `CHK("ieee_null", 1'b1, ieee_default_mode_q)
        $display("test null done");
    endtask

    initial
    begin
        fails = 0;
        checks = 0;
        rst_n = 1'b0;
        null_restore = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_ctrl();
        t_merge();
        t_keep();
        t_null();
        finish_test();
    end

    // hang guard
    initial
    begin
        repeat (5000) @(posedge clk);
        fails++;
        finish_test();
    end
endmodule // fpu_status_control_regs_tb
